/* File: src/sadc_xfer_ctrl.sv */
// top of the converter transfer control: serial framing, acquisition,
// conversion timing and result shifting
// assumes host pins asynchronous to CLK_I; analog result arrives as a code
//
// Behaviour
// - select change valid after 1.425 us stable
// - ignore inputs until select has settled low
// - select high disables address and clock only after the same 1.425 us settle
// - 10 or 11-16 clocks with select; 10 or 16 clocks without select
// - result saturates at all ones or zeros
// - address and result are positive logic
// - self-test addresses give 512, 0, 1023
// - sample six transfer-clock periods before converting
// - done low after tenth fall, high when finished
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_xfer_ctrl #(
    parameter int ADDR_BITS = `SADC_ADDR_BITS,
    parameter int RES_BITS  = `SADC_RES_BITS,
    parameter int CONV_CYC  = `SADC_CONV_CYC,
    parameter int SETTLE_CYC = `SADC_SEL_SETTLE_CYC
) (
    // clock and reset
    input  wire logic                CLK_I,
    input  wire logic                RST_I,
    // host serial pins
    input  wire logic                SEL_N_I,
    input  wire logic                SCLK_I,
    input  wire logic                ADDR_I,
    output logic                     DOUT_O,
    output logic                     DOUT_OE_O,
    output logic                     DONE_O,
    // analog front end
    input  wire logic [RES_BITS-1:0] CODE_I,
    input  wire logic                OVER_I,
    input  wire logic                UNDER_I,
    output logic [ADDR_BITS-1:0]     CHAN_O,
    output logic                     SAMPLE_O
);
    sadc_sync_if s();
    sadc_pin_filter #(.SETTLE_CYC(SETTLE_CYC)) u_filt (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .sel_n_i (SEL_N_I),
        .sclk_i  (SCLK_I),
        .addr_i  (ADDR_I),
        .s       (s)
    );

    sadc_pkg::sadc_state_type st_q, st_d;   // frame state
    logic [4:0]           nclk_q, nclk_d;   // falling edges this frame
    logic [4:0]           nrise_q, nrise_d; // rising edges this frame
    logic [ADDR_BITS-1:0] ashf_q, ashf_d;   // address shift
    logic [ADDR_BITS-1:0] chan_q, chan_d;   // channel being sampled
    logic [RES_BITS-1:0]  res_q, res_d;     // last result
    logic [RES_BITS-1:0]  oshf_q, oshf_d;   // output shift
    logic [15:0]          ccnt_q, ccnt_d;   // conversion timer
    logic                 done_q, done_d;
    logic                 samp_q, samp_d;
    logic                 dout_q, dout_d;
    logic                 oe_q, oe_d;
    logic                 sel_old_q, sel_old_d;
    logic                 active;           // control inputs honoured
    logic [RES_BITS-1:0]  conv_code;        // code seen at conversion end

    // only filtered select low opens the port; done plays no part
    assign active = ~s.sel_n;

    // result selection: self-test codes, then saturation
    always_comb begin
        if (chan_q == `SADC_TEST_MID_ADDR) begin
            conv_code = `SADC_TEST_MID_CODE;
        end else if (chan_q == `SADC_TEST_LOW_ADDR) begin
            conv_code = `SADC_TEST_LOW_CODE;
        end else if (chan_q == `SADC_TEST_HIGH_ADDR) begin
            conv_code = `SADC_TEST_HIGH_CODE;
        end else if (OVER_I) begin
            conv_code = `SADC_FULL_CODE;
        end else if (UNDER_I) begin
            conv_code = `SADC_ZERO_CODE;
        end else begin
            conv_code = CODE_I;
        end
    end

    // frame sequencer next values
    always_comb begin
        st_d      = st_q;
        nclk_d    = nclk_q;
        nrise_d   = nrise_q;
        ashf_d    = ashf_q;
        chan_d    = chan_q;
        res_d     = res_q;
        oshf_d    = oshf_q;
        ccnt_d    = ccnt_q;
        done_d    = done_q;
        samp_d    = samp_q;
        dout_d    = dout_q;
        oe_d      = active;
        sel_old_d = s.sel_n;
        // fresh select-low frame: MSB already on the pin
        if (sel_old_q && !s.sel_n && st_q != sadc_pkg::SADC_CONV) begin
            st_d    = sadc_pkg::SADC_SHIFT;
            nclk_d  = 5'h00;
            nrise_d = 5'h00;
            oshf_d  = res_q;
            dout_d  = res_q[RES_BITS-1];
        end
        case (st_q)
            sadc_pkg::SADC_IDLE: begin
                // without select, first clock after done starts a frame
                if (active && s.sclk_rise) begin
                    if (nrise_q > 5'(`SADC_FRAME_CLKS) && nrise_q < 5'(`SADC_MAX_CLKS)) begin
                        // rest of a tail that outlasted the conversion, not a new frame
                        nrise_d = nrise_q + 5'h01;
                    end else begin
                        st_d    = sadc_pkg::SADC_SHIFT;
                        nclk_d  = 5'h00;
                        nrise_d = 5'h01;
                        ashf_d  = {ashf_q[ADDR_BITS-2:0], s.addr};
                        oshf_d  = res_q;
                    end
                end
            end
            sadc_pkg::SADC_SHIFT: begin
                if (!active) begin
                    st_d = sadc_pkg::SADC_IDLE;
                end else begin
                    if (s.sclk_rise) begin
                        nrise_d = nrise_q + 5'h01;
                        if (nrise_q < 5'(ADDR_BITS)) begin
                            ashf_d = {ashf_q[ADDR_BITS-2:0], s.addr};
                        end
                    end
                    if (s.sclk_fall) begin
                        nclk_d = nclk_q + 5'h01;
                        oshf_d = {oshf_q[RES_BITS-2:0], 1'b0};
                        dout_d = oshf_q[RES_BITS-2];
                        if (nclk_q == 5'(ADDR_BITS - 1)) begin
                            chan_d = ashf_q;
                        end
                        // acquisition spans six clock periods
                        if (nclk_q == 5'(`SADC_ACQ_START - 1)) begin
                            samp_d = 1'b1;
                        end
                        if (nclk_q == 5'(`SADC_FRAME_CLKS - 1)) begin
                            samp_d = 1'b0;
                            done_d = 1'b0;
                            ccnt_d = 16'h0000;
                            st_d   = sadc_pkg::SADC_CONV;
                        end
                    end
                end
            end
            sadc_pkg::SADC_CONV: begin
                // extra clocks 11..16 are tolerated; lie with the host
                ccnt_d = ccnt_q + 16'h0001;
                // tail clocks still counted so idle can swallow the rest
                if (active && s.sclk_rise && nrise_q < 5'(`SADC_MAX_CLKS)) begin
                    nrise_d = nrise_q + 5'h01;
                end
                if (ccnt_q >= 16'(CONV_CYC - 1)) begin
                    res_d  = conv_code;
                    oshf_d = conv_code;
                    dout_d = conv_code[RES_BITS-1];
                    done_d = 1'b1;
                    st_d   = sadc_pkg::SADC_IDLE;
                end
            end
            default: begin
                st_d = sadc_pkg::SADC_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q      <= sadc_pkg::SADC_IDLE;
            nclk_q    <= 5'h00;
            nrise_q   <= 5'h00;
            ashf_q    <= 4'h0;
            chan_q    <= 4'h0;
            res_q     <= 10'h000;
            oshf_q    <= 10'h000;
            ccnt_q    <= 16'h0000;
            done_q    <= 1'b1;
            samp_q    <= 1'b0;
            dout_q    <= 1'b0;
            oe_q      <= 1'b0;
            sel_old_q <= 1'b1;
        end else begin
            st_q      <= st_d;
            nclk_q    <= nclk_d;
            nrise_q   <= nrise_d;
            ashf_q    <= ashf_d;
            chan_q    <= chan_d;
            res_q     <= res_d;
            oshf_q    <= oshf_d;
            ccnt_q    <= ccnt_d;
            done_q    <= done_d;
            samp_q    <= samp_d;
            dout_q    <= dout_d;
            oe_q      <= oe_d;
            sel_old_q <= sel_old_d;
        end
    end

    assign DOUT_O    = dout_q;
    assign DOUT_OE_O = oe_q;
    assign DONE_O    = done_q;
    assign CHAN_O    = chan_q;
    assign SAMPLE_O  = samp_q;
endmodule

/* File: src/sadc_cfg.svh */
// constants for the serial converter transfer control
// assumes a 20 MHz system clock; included by the design files
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
`define SADC_CLK_NS          50
`define SADC_SEL_SETTLE_NS   1425
// least time rounds up to whole cycles
`define SADC_SEL_SETTLE_CYC  ((`SADC_SEL_SETTLE_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_CONV_NS         21000
// longest time rounds down
`define SADC_CONV_CYC        (`SADC_CONV_NS / `SADC_CLK_NS)
`define SADC_ADDR_BITS       4
`define SADC_RES_BITS        10
`define SADC_ACQ_START       4
`define SADC_ACQ_PERIODS     6
`define SADC_FRAME_CLKS      10
// longest select-less sequence; tail clocks up to here are swallowed
`define SADC_MAX_CLKS        16
`define SADC_TEST_MID_ADDR   4'hB
`define SADC_TEST_LOW_ADDR   4'hC
`define SADC_TEST_HIGH_ADDR  4'hD
`define SADC_TEST_MID_CODE   10'h200
`define SADC_TEST_LOW_CODE   10'h000
`define SADC_TEST_HIGH_CODE  10'h3FF
`define SADC_FULL_CODE       10'h3FF
`define SADC_ZERO_CODE       10'h000
`endif

/* File: src/sadc_pkg.sv */
// types for the serial converter transfer control
// assumes nothing beyond the config header
package sadc_pkg;
    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_SHIFT,
        SADC_CONV
    } sadc_state_type;
endpackage

/* File: src/sadc_sync_if.sv */
// carrier between the top and its pin filter
// assumes a single clock domain on both ends
`timescale 1ns/1ps
interface sadc_sync_if;
    logic sel_n;      // filtered select, active low
    logic sclk;       // synchronised transfer clock
    logic addr;       // synchronised address bit
    logic sclk_rise;  // one-cycle pulse
    logic sclk_fall;  // one-cycle pulse
    modport filt (output sel_n, sclk, addr, sclk_rise, sclk_fall);
    modport core (input  sel_n, sclk, addr, sclk_rise, sclk_fall);
endinterface

/* File: src/sadc_pin_filter.sv */
// pin synchronisers, select settle filter and clock edge finder
// assumes pins asynchronous to CLK_I
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_pin_filter #(
    parameter int SETTLE_CYC = `SADC_SEL_SETTLE_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // raw pins
    input  wire logic sel_n_i,
    input  wire logic sclk_i,
    input  wire logic addr_i,
    // filtered outputs
    sadc_sync_if.filt s
);
    logic [2:0]  meta_q, meta_d;     // first stage, read only by stage two
    logic [2:0]  sync_q, sync_d;     // second stage
    logic        sclk_old_q, sclk_old_d;
    logic        sel_q, sel_d;       // accepted select level
    logic [10:0] cnt_q, cnt_d;       // stability counter

    // next values: a new select level counts only once it held steady
    always_comb begin
        meta_d     = {sel_n_i, sclk_i, addr_i};
        sync_d     = meta_q;
        sclk_old_d = sync_q[1];
        sel_d      = sel_q;
        cnt_d      = 11'h000;
        if (sync_q[2] != sel_q) begin
            // noise shorter than the window restarts the count
            if (cnt_q >= 11'(SETTLE_CYC - 1)) begin
                sel_d = sync_q[2];
            end else begin
                cnt_d = cnt_q + 11'h001;
            end
        end
    end

    // registers only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q     <= 3'h4;
            sync_q     <= 3'h4;
            sclk_old_q <= 1'b0;
            sel_q      <= 1'b1;
            cnt_q      <= 11'h000;
        end else begin
            meta_q     <= meta_d;
            sync_q     <= sync_d;
            sclk_old_q <= sclk_old_d;
            sel_q      <= sel_d;
            cnt_q      <= cnt_d;
        end
    end

    assign s.sel_n     = sel_q;
    assign s.sclk      = sync_q[1];
    assign s.addr      = sync_q[0];
    assign s.sclk_rise = sync_q[1] & ~sclk_old_q;
    assign s.sclk_fall = ~sync_q[1] & sclk_old_q;
endmodule

/* File: verification/sadc_xfer_ctrl_checker.sv */
// port checker for the converter transfer control
// assumes one CLK_I domain; bound onto every sadc_xfer_ctrl
`timescale 1ns/1ps
module sadc_xfer_checker #(
    parameter int ADDR_BITS  = 4,
    parameter int CONV_CYC   = 420,
    parameter int SETTLE_CYC = 29
) (
    input wire logic                 CLK_I,
    input wire logic                 RST_I,
    input wire logic                 SEL_N_I,
    input wire logic                 SCLK_I,
    input wire logic                 DOUT_O,
    input wire logic                 DOUT_OE_O,
    input wire logic                 DONE_O,
    input wire logic [ADDR_BITS-1:0] CHAN_O,
    input wire logic                 SAMPLE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic [15:0] lo_q;  // cycles select pin has been low
    logic [15:0] hi_q;  // cycles select pin has been high
    logic [15:0] dl_q;  // cycles done has been low
    logic [3:0]  sf_q;  // pin falls seen inside the sample window
    // run-length counters; long waits cannot be unrolled as repetitions
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            lo_q <= '0;
            hi_q <= '0;
            dl_q <= '0;
            sf_q <= '0;
        end else begin
            lo_q <= SEL_N_I ? 16'h0 : lo_q + 16'h1;
            hi_q <= SEL_N_I ? hi_q + 16'h1 : 16'h0;
            dl_q <= DONE_O ? 16'h0 : dl_q + 16'h1;
            sf_q <= !SAMPLE_O ? 4'h0 : sf_q + 4'($fell(SCLK_I));
        end
    end
    chk_sel_short: assert property ($fell(SEL_N_I) && !DOUT_OE_O |=> !DOUT_OE_O [*8])
        else $error("output enabled too soon after select fell");
    chk_sel_settle: assert property ($rose(DOUT_OE_O) |-> lo_q >= SETTLE_CYC)
        else $error("output enabled before select settled");
    chk_sel_release: assert property (hi_q >= SETTLE_CYC + 4 |-> !DOUT_OE_O)
        else $error("output still enabled long after select rose");
    chk_done_fall: assert property ($fell(DONE_O) |-> $fell(SAMPLE_O))
        else $error("done fell away from end of sampling");
    chk_conv_length: assert property ($rose(DONE_O) |-> dl_q + 1 >= CONV_CYC && dl_q <= CONV_CYC + 1)
        else $error("conversion length wrong");
    chk_sample_window: assert property ($fell(SAMPLE_O) |-> sf_q == 4'h6)
        else $error("sample window not six clock periods");
    chk_tail_ignored: assert property (!DONE_O && !$past(DONE_O) && DOUT_OE_O && $past(DOUT_OE_O)
        |-> $stable(DOUT_O))
        else $error("result moved during conversion");
    chk_chan_latch: assert property ($changed(CHAN_O) |-> $rose(SAMPLE_O))
        else $error("channel changed outside fourth clock fall");
endmodule
bind sadc_xfer_ctrl sadc_xfer_checker #(.ADDR_BITS(ADDR_BITS), .CONV_CYC(CONV_CYC), .SETTLE_CYC(SETTLE_CYC))
    u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .SEL_N_I(SEL_N_I), .SCLK_I(SCLK_I), .DOUT_O(DOUT_O),
    .DOUT_OE_O(DOUT_OE_O), .DONE_O(DONE_O), .CHAN_O(CHAN_O), .SAMPLE_O(SAMPLE_O));

/* File: verification/sadc_host_model.sv */
// host serial port model: select, 400 ns transfer clock, address out
// assumes the device system clock; pins change on its falling edge
`timescale 1ns/1ps
module sadc_host_model (
    // pacing
    input  wire logic clk_i,
    // device pins
    output logic      sel_n_o,
    output logic      sclk_o,
    output logic      addr_o,
    input  wire logic dout_i
);
    initial begin
        sel_n_o = 1'b1;
        sclk_o = 1'b0;
        addr_o = 1'b0;
    end
    // one transfer; clock idles low between frames
    task automatic xfer(input logic [3:0] a, input int n, input bit cs, output logic [9:0] r);
        sel_n_o = 1'b0;
        if (cs) repeat (40) @(negedge clk_i);
        for (int k = 0; k < n; k++) begin
            addr_o = (k < 4) ? a[3-k] : ~addr_o;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            if (k < 10) r[9-k] = dout_i;
            sclk_o = 1'b0;
        end
        // released address line must not keep a stale level
        addr_o = ~addr_o;
        repeat (8) @(negedge clk_i);
        if (cs) sel_n_o = 1'b1;
    endtask
endmodule

/* File: verification/sadc_xfer_ctrl_tb.sv */
// testbench for the converter transfer control, host model on the pins
// assumes conversion shortened to 40 cycles; checker bound alongside
`timescale 1ns/1ps
module sadc_xfer_ctrl_tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       sel_n, sclk, addr, dout, dout_oe, done, over, under, sample;
    logic       dout_pin;  // line as the host sees it
    logic [9:0] code;
    logic [3:0] chan;
    int         n_errors = 0;
    int         checks_done = 0;
    int         cyc = 0;
    always #25 clk = ~clk;
    sadc_xfer_ctrl #(.CONV_CYC(40)) DUT (.CLK_I(clk), .RST_I(rst), .SEL_N_I(sel_n), .SCLK_I(sclk),
        .ADDR_I(addr), .DOUT_O(dout), .DOUT_OE_O(dout_oe), .DONE_O(done), .CODE_I(code),
        .OVER_I(over), .UNDER_I(under), .CHAN_O(chan), .SAMPLE_O(sample));
    // a disabled output shows the inverse, so a read while undriven cannot pass
    assign dout_pin = dout_oe ? dout : ~dout;
    sadc_host_model host (.clk_i(clk), .sel_n_o(sel_n), .sclk_o(sclk), .addr_o(addr), .dout_i(dout_pin));
    task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one transfer, then wait out the conversion and the select settle
    task automatic frame(input logic [3:0] a, input int n, input bit cs, input logic [9:0] exp);
        logic [9:0] r;
        host.xfer(a, n, cs, r);
        cmp("result", exp, r);
        cmp("channel", {6'h0, a}, {6'h0, chan});
        if (n == 10) cmp("done low", 10'h0, {9'h0, done});
        for (int i = 0; i < 100 && done !== 1'b1; i++) @(negedge clk);
        cmp("done high", 10'h1, {9'h0, done});
        repeat (40) @(negedge clk);
    endtask
    // self-test channels; each result shows one frame later
    task automatic t_selftest;
        logic [3:0] adr [4] = '{4'hB, 4'hC, 4'hD, 4'h0};
        logic [9:0] res [4] = '{10'h000, 10'h200, 10'h000, 10'h3FF};
        for (int i = 0; i < 4; i++) frame(adr[i], 10, 1'b1, res[i]);
    endtask
    // out-of-range inputs clip, with longer frames
    task automatic t_saturate;
        over = 1'b1;
        frame(4'h1, 10, 1'b1, 10'h155);
        over = 1'b0;
        under = 1'b1;
        frame(4'h2, 12, 1'b1, 10'h3FF);
        under = 1'b0;
        frame(4'h3, 16, 1'b1, 10'h000);
    endtask
    // short select pulse ignored, held select accepted then dropped
    task automatic t_select;
        host.sel_n_o = 1'b0;
        repeat (20) @(negedge clk);
        host.sel_n_o = 1'b1;
        repeat (12) @(negedge clk);
        cmp("short select", 10'h0, {9'h0, dout_oe});
        repeat (30) @(negedge clk);
        host.sel_n_o = 1'b0;
        repeat (40) @(negedge clk);
        cmp("held select", 10'h1, {9'h0, dout_oe});
        host.sel_n_o = 1'b1;
        repeat (40) @(negedge clk);
        cmp("released select", 10'h0, {9'h0, dout_oe});
    endtask
    // select tied low, sixteen, sixteen then ten clocks after done is high
    task automatic t_nosel;
        host.sel_n_o = 1'b0;
        code = 10'h2AA;
        repeat (40) @(negedge clk);
        frame(4'h5, 16, 1'b0, 10'h155);
        frame(4'h6, 16, 1'b0, 10'h2AA);
        frame(4'h7, 10, 1'b0, 10'h2AA);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_sim;
        end
    end
    initial begin
        code = 10'h155;
        over = 1'b0;
        under = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        cmp("reset outputs", 10'h002, {3'h0, chan, dout_oe, done, sample});
        t_selftest;
        t_saturate;
        t_select;
        t_nosel;
        end_sim;
    end
endmodule
